/* dlftw_top.sv */
// Purpose: downlink frame offset, cell delay, sync stamps and arrival window
// Assumes: APB slave, zero wait states, inputs synchronous to pclk
// Notes: window arithmetic in 0.125 ms ticks modulo the CFN length
// Overview of operation
// R1: per-link frame offset in 256-chip steps, 0 to 38144 chips.
// R2: applied offset is the chip offset rounded to nearest 256 chips.
// R3: remainder 1..127 rounds down, 128..255 up, zero stays.
// R4: dedicated channel frame starts at rounded offset after cell frame timing.
// R5: cell frame numbering and sync channel delayed by cell delay after node counter.
// R6: cell delay programmable in 256-chip steps, zero to nine.
// R7: sync channel burst lasts 256 chips.
// R8: downlink sync frame arrival captures node counter at 0.125 ms resolution.
// R9: uplink sync frame send captures and reports node counter.
// R10: controller stamps downlink sync frames with its own counter.
// R11: controller keeps uplink reply arrival time locally only.
// R12: window start held in 1 ms steps before window end.
// R13: frame before window start triggers timing adjustment response.
// R14: window end held in 1 ms steps before latest arrival point.
// R15: frame after window end triggers timing adjustment response.
// R16: latest arrival is processing time before air start; later frames discarded.
// R17: frames between window end and latest arrival still processed.
// R18: arrival offset is window end minus arrival in 125 us steps, signed.
// R19: controller computes rounded offsets for all active-set links.
// R20: chip counter wraps at 38400, window arithmetic wraps at CFN length.
// R21: status event on every adjustment response or discard.
`timescale 1ns/1ps
`default_nettype none
module dlftw_top
  import dlftw_pkg::*;
#(
  parameter int unsigned CHIP_INC = ACC_INC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic dl_sync_rx,
  input wire logic ul_sync_tx,
  input wire logic df_valid,
  input wire logic [7:0] df_cfn,
  output logic cell_frame_start,
  output logic [11:0] cell_sfn,
  output logic sch_active,
  output logic dpch_frame_start,
  output logic [18:0] ul_sync_t3,
  output logic ul_sync_t3_valid,
  output logic df_process,
  output logic df_discard,
  output logic ta_send,
  output logic [15:0] ta_toa,
  output logic [7:0] ta_cfn,
  output logic status_event
);
  dlftw_tick_if tk();

  dlftw_node_timer #(.CHIP_INC(CHIP_INC)) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk.src)
  );

  logic run_reg;
  logic [15:0] chip_off_reg;
  logic [15:0] frame_off_reg;
  logic [3:0] cell_dly_reg;
  logic [10:0] toaws_reg;
  logic [11:0] toawe_reg;
  logic [15:0] tproc_reg;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] ev_set;
  logic [18:0] t2_reg;

  // ==========================================================
  // helpers
  function automatic logic [15:0] mod_sub(input logic [15:0] a, input logic [15:0] b, input logic [15:0] m);
    logic [16:0] t;
    t = {1'b0, a} + {1'b0, m} - {1'b0, b};
    mod_sub = (a >= b) ? a - b : t[15:0];
  endfunction

  function automatic logic [15:0] mod_add(input logic [15:0] a, input logic [15:0] b, input logic [15:0] m);
    logic [16:0] t;
    t = {1'b0, a} + {1'b0, b};
    mod_add = (t >= {1'b0, m}) ? 16'(t - {1'b0, m}) : t[15:0];
  endfunction

  function automatic logic reg_mapped(input logic [11:0] a);
    reg_mapped = (a[1:0] == 2'b00) && (a <= ADDR_NODE_TIME);
  endfunction

  // ==========================================================
  // apb slave
  logic setup_ph;
  logic wr_acc;
  logic [31:0] rd_mux;
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite && pready && reg_mapped(paddr);

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (paddr)
      ADDR_CTRL: rd_mux[CTRL_RUN] = run_reg;
      ADDR_CHIP_OFF: rd_mux[15:0] = chip_off_reg;
      ADDR_FRAME_OFF: rd_mux[15:0] = frame_off_reg;
      ADDR_CELL_DLY: rd_mux[3:0] = cell_dly_reg;
      ADDR_WINDOW: rd_mux = {4'h0, toawe_reg, 5'h00, toaws_reg};
      ADDR_TPROC: rd_mux[15:0] = tproc_reg;
      ADDR_STATUS: rd_mux[2:0] = status_reg;
      ADDR_T2: rd_mux[18:0] = t2_reg;
      ADDR_T3: rd_mux[18:0] = ul_sync_t3;
      ADDR_TOA: rd_mux[15:0] = ta_toa;
      ADDR_NODE_TIME: rd_mux[18:0] = tk.tick_cnt;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph && !reg_mapped(paddr);
      if (setup_ph && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= 1'b0;
      chip_off_reg <= 16'h0000;
      cell_dly_reg <= 4'h0;
      toaws_reg <= RST_TOAWS;
      toawe_reg <= RST_TOAWE;
      tproc_reg <= RST_TPROC;
    end else if (wr_acc) begin
      unique case (paddr)
        ADDR_CTRL: run_reg <= pwdata[CTRL_RUN];
        ADDR_CHIP_OFF: chip_off_reg <= (pwdata[15:0] >= CHIPS_PER_FRAME) ? CHIPS_PER_FRAME - 16'h0001 : pwdata[15:0];
        ADDR_CELL_DLY: cell_dly_reg <= (pwdata[3:0] > CELL_DLY_MAX) ? CELL_DLY_MAX : pwdata[3:0]; // [R6]
        ADDR_WINDOW: begin
          toaws_reg <= pwdata[10:0]; // [R12]
          toawe_reg <= (pwdata[WIN_TOAWE_LSB +: 12] > 12'h9FF) ? 12'h9FF : pwdata[WIN_TOAWE_LSB +: 12]; // [R14]
        end
        ADDR_TPROC: tproc_reg <= (pwdata[15:0] >= CFN_TICKS) ? CFN_TICKS - 16'h0001 : pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // offset rounding to 256-chip boundary
  logic [15:0] round_up;
  assign round_up = {chip_off_reg[15:8], 8'h00} + 16'h0100;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_off_reg <= 16'h0000;
    end else if (!chip_off_reg[7]) begin
      frame_off_reg <= {chip_off_reg[15:8], 8'h00}; // [R2] [R3]
    end else begin
      frame_off_reg <= (round_up >= CHIPS_PER_FRAME) ? 16'h0000 : round_up; // [R1] [R3]
    end
  end

  // ==========================================================
  // cell timing
  logic [15:0] dly_chips;
  logic [15:0] cell_pos;
  logic [15:0] slot_pos;
  assign dly_chips = {4'h0, cell_dly_reg, 8'h00};
  assign cell_pos = mod_sub(tk.chip_pos, dly_chips, CHIPS_PER_FRAME); // [R5]
  assign slot_pos = cell_pos % SLOT_CHIPS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_frame_start <= 1'b0;
      cell_sfn <= 12'h000;
      sch_active <= 1'b0;
      dpch_frame_start <= 1'b0;
    end else begin
      cell_frame_start <= tk.chip_en && (cell_pos == 16'h0000); // [R5]
      cell_sfn <= (tk.chip_pos < dly_chips) ? tk.bfn - 12'h001 : tk.bfn; // [R5]
      sch_active <= slot_pos < SCH_CHIPS; // [R7]
      dpch_frame_start <= tk.chip_en && (cell_pos == frame_off_reg); // [R4]
    end
  end

  // ==========================================================
  // node synchronisation stamps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t2_reg <= 19'h00000;
      ul_sync_t3 <= 19'h00000;
      ul_sync_t3_valid <= 1'b0;
    end else begin
      ul_sync_t3_valid <= run_reg && ul_sync_tx;
      if (run_reg && dl_sync_rx) begin
        t2_reg <= tk.tick_cnt; // [R8]
      end
      if (run_reg && ul_sync_tx) begin
        ul_sync_t3 <= tk.tick_cnt; // [R9]
      end
    end
  end

  // ==========================================================
  // arrival window classification
  logic [15:0] off_ticks;
  logic [15:0] air_t;
  logic [15:0] ltoa_t;
  logic [15:0] we_t;
  logic [15:0] toa_raw;
  logic [15:0] lag;
  logic late;
  logic early;
  logic discard;
  logic df_take;
  assign off_ticks = frame_off_reg / 16'(CHIPS_PER_TICK);
  assign air_t = mod_add(16'(df_cfn) * TICKS_PER_FRAME, off_ticks, CFN_TICKS); // [R20]
  assign ltoa_t = mod_sub(air_t, tproc_reg, CFN_TICKS); // [R16]
  assign we_t = mod_sub(ltoa_t, {1'b0, toawe_reg, 3'b000}, CFN_TICKS); // [R14]
  assign toa_raw = mod_sub(we_t, tk.cfn_tick, CFN_TICKS); // [R18]
  assign lag = CFN_TICKS - toa_raw;
  assign late = toa_raw >= HALF_CFN_TICKS; // [R15]
  assign early = !late && (toa_raw > {2'b00, toaws_reg, 3'b000}); // [R13]
  assign discard = late && (lag > {1'b0, toawe_reg, 3'b000}); // [R16]
  assign df_take = run_reg && df_valid;
  assign ev_set = {df_take && discard, df_take && late, df_take && early};
  assign status_next = (status_reg & ~((wr_acc && paddr == ADDR_STATUS) ? pwdata[2:0] : 3'b000)) | ev_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      df_process <= 1'b0;
      df_discard <= 1'b0;
      ta_send <= 1'b0;
      ta_toa <= 16'h0000;
      ta_cfn <= 8'h00;
    end else begin
      df_process <= df_take && !discard; // [R17]
      df_discard <= df_take && discard; // [R16]
      ta_send <= df_take && (early || late); // [R13] [R15]
      if (df_take) begin
        ta_toa <= late ? 16'(toa_raw - CFN_TICKS) : toa_raw; // [R18]
        ta_cfn <= df_cfn;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 3'b000;
      status_event <= 1'b0;
    end else begin
      status_reg <= status_next; // [R21]
      status_event <= |ev_set; // [R21]
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  off_grid_a: assert property (frame_off_reg[7:0] == 8'h00 && frame_off_reg <= OFF_MAX) // [R1]
    else $error("frame offset off grid or range");
  round_up_a: assert property (chip_off_reg[7] && round_up < CHIPS_PER_FRAME && $stable(chip_off_reg) // [R3]
    |=> frame_off_reg == $past(chip_off_reg) + 16'h0100 - {8'h00, $past(chip_off_reg[7:0])})
    else $error("offset not rounded up");
  round_dn_a: assert property (!chip_off_reg[7] && $stable(chip_off_reg) // [R2]
    |=> frame_off_reg == $past(chip_off_reg) - {8'h00, $past(chip_off_reg[7:0])})
    else $error("offset not rounded down");
  cell_dly_a: assert property (cell_dly_reg <= CELL_DLY_MAX) // [R6]
    else $error("cell delay above nine steps");
  cell_start_a: assert property (cell_frame_start && $past(cell_dly_reg) == cell_dly_reg // [R5]
    |-> $past(tk.chip_pos) == dly_chips && sch_active)
    else $error("cell frame start misplaced");
  dpch_start_a: assert property ($rose(dpch_frame_start) |-> $past(cell_pos) == $past(frame_off_reg)) // [R4]
    else $error("dedicated frame start misplaced");
  chip_wrap_a: assert property (tk.chip_pos < CHIPS_PER_FRAME && tk.cfn_tick < CFN_TICKS) // [R20]
    else $error("timing counter out of range");
  t2_stamp_a: assert property (run_reg && dl_sync_rx |=> t2_reg == $past(tk.tick_cnt)) // [R8]
    else $error("downlink sync stamp wrong");
  t3_stamp_a: assert property (run_reg && ul_sync_tx |=> ul_sync_t3_valid && ul_sync_t3 == $past(tk.tick_cnt)) // [R9]
    else $error("uplink sync stamp wrong");
  early_adj_a: assert property (df_take && early |=> ta_send && df_process ##1 status_reg[ST_EARLY]) // [R13]
    else $error("early frame not answered");
  late_keep_a: assert property (df_take && late && !discard |=> ta_send && df_process && !df_discard) // [R15] [R17]
    else $error("late frame not kept and answered");
  discard_a: assert property (df_discard |-> !df_process && ta_send && $signed(ta_toa) < 0) // [R16]
    else $error("discard without late arrival");
  toa_sign_a: assert property (ta_send && !ta_toa[15] |-> ta_toa > {2'b00, toaws_reg, 3'b000}) // [R18]
    else $error("positive offset not beyond start");
  event_a: assert property ((ta_send || df_discard) |-> status_event) // [R21]
    else $error("status event missing");

  early_c: cover property (df_take && early);
  late_c: cover property (df_take && late && !discard);
  discard_c: cover property (df_take && discard);
  sync_c: cover property (dl_sync_rx && run_reg ##[1:20] ul_sync_tx);
endmodule
`default_nettype wire

/* dlftw_pkg.sv */
// Purpose: shared constants for the downlink frame timing window block
// Assumes: 100 MHz pclk, 3.84 Mchip/s node timing
// Notes: all offsets are APB byte addresses
package dlftw_pkg;
  // ==========================================================
  // clock and chip timing
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned CHIP_KHZ = 3840;
  localparam int unsigned ACC_MOD = CLK_KHZ / 10;
  localparam int unsigned ACC_INC = CHIP_KHZ / 10;
  localparam int unsigned TICK_NS = 125000;
  localparam int unsigned CHIPS_PER_TICK = TICK_NS / 1000 * CHIP_KHZ / 1000;
  localparam logic [15:0] CHIPS_PER_FRAME = 16'h9600;
  localparam logic [15:0] OFF_MAX = 16'h9500;
  localparam logic [15:0] SLOT_CHIPS = 16'h0A00;
  localparam logic [15:0] SCH_CHIPS = 16'h0100;
  localparam logic [3:0] CELL_DLY_MAX = 4'h9;
  localparam logic [18:0] NODE_TICKS = 19'h50000;
  localparam logic [15:0] CFN_TICKS = 16'h5000;
  localparam logic [15:0] HALF_CFN_TICKS = 16'h2800;
  localparam logic [15:0] TICKS_PER_FRAME = 16'h0050;
  // ==========================================================
  // register offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CHIP_OFF = 12'h004;
  localparam logic [11:0] ADDR_FRAME_OFF = 12'h008;
  localparam logic [11:0] ADDR_CELL_DLY = 12'h00C;
  localparam logic [11:0] ADDR_WINDOW = 12'h010;
  localparam logic [11:0] ADDR_TPROC = 12'h014;
  localparam logic [11:0] ADDR_STATUS = 12'h018;
  localparam logic [11:0] ADDR_T2 = 12'h01C;
  localparam logic [11:0] ADDR_T3 = 12'h020;
  localparam logic [11:0] ADDR_TOA = 12'h024;
  localparam logic [11:0] ADDR_NODE_TIME = 12'h028;
  // ==========================================================
  // field positions and reset values
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned WIN_TOAWE_LSB = 16;
  localparam int unsigned ST_EARLY = 0;
  localparam int unsigned ST_LATE = 1;
  localparam int unsigned ST_DISC = 2;
  localparam logic [15:0] RST_TPROC = 16'h0008;
  localparam logic [10:0] RST_TOAWS = 11'h000;
  localparam logic [11:0] RST_TOAWE = 12'h000;
endpackage

/* dlftw_tick_if.sv */
// Purpose: node timing bundle from the timer to the window logic
// Assumes: single pclk domain
// Notes: chip_en pulses once per chip, counters already updated
`timescale 1ns/1ps
`default_nettype none
interface dlftw_tick_if;
  logic chip_en;
  logic [15:0] chip_pos;
  logic [11:0] bfn;
  logic [18:0] tick_cnt;
  logic [15:0] cfn_tick;
  modport src(output chip_en, output chip_pos, output bfn, output tick_cnt, output cfn_tick);
  modport dst(input chip_en, input chip_pos, input bfn, input tick_cnt, input cfn_tick);
endinterface
`default_nettype wire

/* dlftw_node_timer.sv */
// Purpose: node frame counter with chip and 0.125 ms resolution
// Assumes: fractional accumulator gives the average chip rate
// Notes: CHIP_INC equal to ACC_MOD gives one chip per cycle
`timescale 1ns/1ps
`default_nettype none
module dlftw_node_timer
  import dlftw_pkg::*;
#(
  parameter int unsigned CHIP_INC = ACC_INC
) (
  input wire logic pclk,
  input wire logic presetn,
  dlftw_tick_if.src tk
);
  logic [14:0] acc_reg;
  logic [14:0] acc_sum;
  logic [8:0] sub_reg;
  logic chip_hit;
  logic tick_hit;

  always_comb begin
    acc_sum = acc_reg + 15'(CHIP_INC);
    chip_hit = acc_sum >= 15'(ACC_MOD);
    tick_hit = chip_hit && (sub_reg == 9'(CHIPS_PER_TICK - 1));
  end

  // ==========================================================
  // chip enable divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= 15'h0000;
      tk.chip_en <= 1'b0;
    end else begin
      acc_reg <= chip_hit ? acc_sum - 15'(ACC_MOD) : acc_sum;
      tk.chip_en <= chip_hit;
    end
  end

  // ==========================================================
  // chip position and frame counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tk.chip_pos <= 16'h0000;
      tk.bfn <= 12'h000;
    end else if (chip_hit) begin
      if (tk.chip_pos == CHIPS_PER_FRAME - 16'h0001) begin // [R20]
        tk.chip_pos <= 16'h0000;
        tk.bfn <= tk.bfn + 12'h001;
      end else begin
        tk.chip_pos <= tk.chip_pos + 16'h0001;
      end
    end
  end

  // ==========================================================
  // 0.125 ms tick counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_reg <= 9'h000;
      tk.tick_cnt <= 19'h00000;
      tk.cfn_tick <= 16'h0000;
    end else if (chip_hit) begin
      sub_reg <= tick_hit ? 9'h000 : sub_reg + 9'h001;
      if (tick_hit) begin
        tk.tick_cnt <= (tk.tick_cnt == NODE_TICKS - 19'h00001) ? 19'h00000 : tk.tick_cnt + 19'h00001;
        tk.cfn_tick <= (tk.cfn_tick == CFN_TICKS - 16'h0001) ? 16'h0000 : tk.cfn_tick + 16'h0001; // [R20]
      end
    end
  end
endmodule
`default_nettype wire

/* dlftw_rnc_model.sv */
// Purpose: controller model feeding data frames and sync requests
// Assumes: pclk domain, signals change just after rising edges
// Notes: frame number shows inverted last value while idle
`timescale 1ns/1ps
`default_nettype none
module dlftw_rnc_model (
  input wire logic pclk,
  output logic df_valid,
  output logic [7:0] df_cfn,
  output logic dl_sync_rx
);
  // ==========================================================
  // controller frame counter and stamps
  logic [18:0] rfn_reg = 19'h00000;
  logic [18:0] t1_reg = 19'h00000;
  logic [18:0] t4_reg = 19'h00000;
  initial begin
    df_valid = 1'b0;
    df_cfn = 8'h00;
    dl_sync_rx = 1'b0;
  end
  always @(posedge pclk) begin
    rfn_reg <= rfn_reg + 19'h00001;
  end
  // ==========================================================
  // link offset rounding done on the controller side
  function automatic logic [15:0] round_off(input logic [15:0] c);
    logic [16:0] s;
    s = ({1'b0, c} + 17'h00080) & 17'h1FF00;
    return (s >= 17'h09600) ? 16'h0000 : s[15:0];
  endfunction
  // ==========================================================
  // transfers
  task automatic send_df(input logic [7:0] c);
    df_valid <= 1'b1;
    df_cfn <= c;
    @(posedge pclk);
    df_valid <= 1'b0;
    df_cfn <= ~c;
    @(posedge pclk);
  endtask
  task automatic send_sync();
    dl_sync_rx <= 1'b1;
    t1_reg <= rfn_reg;
    @(posedge pclk);
    dl_sync_rx <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic note_reply();
    t4_reg <= rfn_reg;
  endtask
endmodule
`default_nettype wire

/* downlink_frame_timing_window_tb_top.sv */
// Purpose: self-checking bench for the frame timing window block
// Assumes: one chip per clock via CHIP_INC
// Notes: frame results checked from a queue of expectations
`timescale 1ns/1ps
`default_nettype none
module downlink_frame_timing_window_tb_top;
  import dlftw_pkg::*;
  typedef struct packed {logic proc; logic disc; logic ta; logic [15:0] toa; logic [7:0] cfn;} dlftw_exp_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ul_sync_tx;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic dl_sync_rx, df_valid, cell_frame_start, sch_active, dpch_frame_start, ul_sync_t3_valid;
  logic df_process, df_discard, ta_send, status_event;
  logic [7:0] df_cfn, ta_cfn;
  logic [11:0] cell_sfn;
  logic [18:0] ul_sync_t3;
  logic [15:0] ta_toa;
  int fails = 0;
  int checks_done = 0;
  int seed = 32'hB519;
  dlftw_exp_t expq[$];
  dlftw_top #(.CHIP_INC(10000)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .dl_sync_rx, .ul_sync_tx, .df_valid, .df_cfn, .cell_frame_start,
    .cell_sfn, .sch_active, .dpch_frame_start, .ul_sync_t3, .ul_sync_t3_valid, .df_process,
    .df_discard, .ta_send, .ta_toa, .ta_cfn, .status_event);
  dlftw_rnc_model u_rnc (.pclk, .df_valid, .df_cfn, .dl_sync_rx);
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) fails++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    rd(a, q);
    chk(q, x);
  endtask
  function automatic logic ev(input int s);
    case (s)
      0: return cell_frame_start;
      1: return dpch_frame_start;
      default: return sch_active;
    endcase
  endfunction
  task automatic wait_ev(input int s, output int t);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (ev(s) !== 1'b1 && n < 50000);
    if (n >= 50000) fails++;
    t = int'($time / 10);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // frame result monitor
  always @(negedge pclk) begin
    dlftw_exp_t e;
    if (df_process === 1'b1 || df_discard === 1'b1 || ta_send === 1'b1 || status_event === 1'b1) begin
      if (expq.size() == 0) chk(32'({df_process, df_discard, ta_send}), 32'h0);
      else begin
        e = expq.pop_front();
        chk(32'({df_process, df_discard, ta_send, status_event}), 32'({e.proc, e.disc, e.ta, e.ta}));
        if (e.ta) chk(32'({ta_toa, ta_cfn}), 32'({e.toa, e.cfn}));
      end
    end
  end
  // ==========================================================
  // clock, watchdog
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #990000;
    fails++;
    give_verdict();
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] a, b, v;
    logic e;
    int t0, t1, n, r;
    int dt[7] = '{17, 16, 0, -1, -8, -9, -100};
    int ro[10] = '{0, 127, 128, 255, 383, 38143, 38271, 38272, 38399, 65535};
    dlftw_exp_t x;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ul_sync_tx = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(ADDR_TPROC, 32'h8);
    rd_chk(ADDR_CTRL, 32'h0);
    rd_chk(ADDR_STATUS, 32'h0);
    apb(1'b0, 12'h02C, 32'h0, a, e);
    chk(32'(e), 32'h1);
    apb(1'b0, 12'h002, 32'h0, a, e);
    chk(32'(e), 32'h1);
    for (int i = 0; i < 18; i++) begin
      v = (i < 10) ? ro[i] : $unsigned($random(seed)) % 38400;
      wr(ADDR_CHIP_OFF, v);
      rd_chk(ADDR_FRAME_OFF, 32'(u_rnc.round_off((v > 38399) ? 16'h95FF : v[15:0])));
    end
    wr(ADDR_CELL_DLY, 32'hC);
    rd_chk(ADDR_CELL_DLY, 32'h9);
    wr(ADDR_CELL_DLY, 32'h0);
    wr(ADDR_CHIP_OFF, 32'd600);
    wait_ev(0, t0);
    wr(ADDR_CELL_DLY, 32'h3);
    wait_ev(0, t1);
    chk(t1 - t0, 32'd768);
    chk(32'(cell_sfn), 32'h1);
    wait_ev(1, t0);
    chk(t0 - t1, 32'd512);
    wait_ev(2, t0);
    n = 0;
    while (sch_active === 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk(n, 32'd256);
    wait_ev(0, t0);
    chk(t0 - t1, 32'd38400);
    chk(32'(cell_sfn), 32'h2);
    wr(ADDR_CHIP_OFF, 32'h0);
    wr(ADDR_WINDOW, 32'h0001_0002);
    rd_chk(ADDR_WINDOW, 32'h0001_0002);
    u_rnc.send_df(8'h05);
    wr(ADDR_CTRL, 32'h1);
    rd(ADDR_NODE_TIME, a);
    u_rnc.send_sync();
    rd(ADDR_T2, b);
    chk(32'(b - a <= 2), 32'h1);
    ul_sync_tx <= 1'b1;
    @(posedge pclk);
    ul_sync_tx <= 1'b0;
    @(negedge pclk);
    chk(32'(ul_sync_t3_valid), 32'h1);
    chk(32'(ul_sync_t3 - a[18:0] <= 19'h4), 32'h1);
    @(posedge pclk);
    u_rnc.note_reply();
    foreach (dt[i]) begin
      rd(ADDR_NODE_TIME, a);
      do rd(ADDR_NODE_TIME, b); while (b == a);
      r = b % 80;
      wr(ADDR_TPROC, 32'(152 - r - dt[i]));
      x.proc = dt[i] >= -8;
      x.disc = dt[i] < -8;
      x.ta = dt[i] > 16 || dt[i] < 0;
      x.toa = dt[i][15:0];
      x.cfn = 8'((b / 80 + 2) % 256);
      expq.push_back(x);
      u_rnc.send_df(x.cfn);
    end
    repeat (4) @(posedge pclk);
    chk(expq.size(), 32'h0);
    rd_chk(ADDR_STATUS, 32'h7);
    wr(ADDR_STATUS, 32'h7);
    rd_chk(ADDR_STATUS, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
